// *** design/fsrs_top.sv ***
// Floppy main status and data rate select register block.
// Assumes an APB master on pclk and core status inputs on pclk.
// Functional notes
// - Status bit 7 is 1 when the host may move a byte.
// - Status bit 6 gives transfer direction: 0 host writes, 1 host reads.
// - Status bit 5 is 1 for non-DMA, 0 for DMA.
// - Status bit 4 is set while a command runs through result phase.
// - Status bits 1 and 0 show seek busy per drive; 3-2 reserved.
// - Offset 04h reads status and writes the rate select register.
// - Effective rate follows the latest rate select write or control register write with the rate write bit (bit 1) set.
// - Software reset leaves the rate select register unchanged.
// - Hardware reset loads rate select with 02h: default precomp, 250 Kbps.
// - Rate select bit 7 gives a self-clearing controller reset.
// - Rate select bit 6 stops clocks until reset or data/status access.
// - Rate select bits 4-2 choose the write precompensation delay.
// - Precompensation applies from a start track, default 0, set through the control register.
// - Either reset bit clears core registers and forces idle.
// - Output-register reset takes priority over rate select reset.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fsrs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_request_flag,
    input wire logic transfer_direction,
    input wire logic non_dma_flag,
    input wire logic command_busy,
    input wire logic second_drive_seek_busy,
    input wire logic first_drive_seek_busy,
    input wire logic [7:0] current_track,
    input wire logic wr_data_in,
    output logic wr_data_out,
    output logic core_reset,
    output logic core_clk_en,
    output logic sep_clk_en,
    output logic [1:0] rate_code
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit_rs;
    logic hit_ctl;
    logic hit_core;
    logic hit_view;
    logic hit_data;
    logic [7:0] rate_sel_r;
    logic out_reset_n_r;
    logic [7:0] track_start_r;
    logic [1:0] dcr_rate_r;
    logic soft_reset_r;
    logic power_down_r;
    logic [1:0] eff_rate_r;
    fsrs_pkg::fsrs_src_type rate_src_r;
    logic [7:0] div_cnt_r;
    logic [7:0] div_max;
    logic [7:0] status_byte;
    logic sep_tick_r;

    assign access = psel && penable;
    assign wr_en = access && pwrite;
    // Read data loads in the setup cycle so it stands when pready is sampled
    assign rd_en = psel && !penable && !pwrite;
    assign hit_rs = (paddr == fsrs_pkg::FSRS_OFS_STATUS_RATE);
    assign hit_ctl = (paddr == fsrs_pkg::FSRS_OFS_CONTROL);
    assign hit_core = (paddr == fsrs_pkg::FSRS_OFS_CORE);
    assign hit_view = (paddr == fsrs_pkg::FSRS_OFS_RATE_VIEW);
    // Data register lives elsewhere; only its touch wakes the clocks
    assign hit_data = (paddr == fsrs_pkg::FSRS_OFS_DATA_TOUCH);
    assign pready = 1'b1;

    // Unmapped addresses answer with an error, no side effect
    assign pslverr = access && !(hit_rs || hit_ctl || hit_core || hit_view || hit_data);

    // ----------------------------------------
    // Main status byte
    // ----------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[fsrs_pkg::FSRS_MS_REQ] = host_request_flag;
        status_byte[fsrs_pkg::FSRS_MS_DIR] = transfer_direction;
        status_byte[fsrs_pkg::FSRS_MS_NDMA] = non_dma_flag;
        status_byte[fsrs_pkg::FSRS_MS_BUSY] = command_busy;
        status_byte[fsrs_pkg::FSRS_MS_SEEK1] = second_drive_seek_busy;
        status_byte[fsrs_pkg::FSRS_MS_SEEK0] = first_drive_seek_busy;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (hit_rs) begin
                prdata <= {24'h00_0000, status_byte};
            end else if (hit_ctl) begin
                prdata <= {8'h00, track_start_r, 6'h00, dcr_rate_r, 7'h00, out_reset_n_r};
            end else if (hit_core) begin
                prdata <= {24'h00_0000, 5'h00, power_down_r, soft_reset_r, core_reset};
            end else if (hit_view) begin
                prdata <= {24'h00_0000, 5'h00, rate_src_r == fsrs_pkg::FSRS_SRC_DCR, eff_rate_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Rate select register
    // ----------------------------------------
    // Write only; soft reset never touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_sel_r <= fsrs_pkg::FSRS_RATE_SEL_RESET;
        end else if (wr_en && hit_rs) begin
            rate_sel_r <= {1'b0, 1'b0, 1'b0, pwdata[4:0]};
        end
    end

    // ----------------------------------------
    // Control register of the surrounding core
    // ----------------------------------------
    // Output-register reset bit, control-register rate and start track
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reset_n_r <= 1'b0;
            dcr_rate_r <= fsrs_pkg::FSRS_RATE_250K;
            track_start_r <= fsrs_pkg::FSRS_TRACK_RESET;
        end else if (wr_en && hit_ctl) begin
            out_reset_n_r <= pwdata[fsrs_pkg::FSRS_CT_OUT_RESET_N];
            if (pwdata[fsrs_pkg::FSRS_CT_DCR_WRITE]) begin
                dcr_rate_r <= pwdata[fsrs_pkg::FSRS_CT_DCR_LO +: 2];
            end
            track_start_r <= pwdata[fsrs_pkg::FSRS_CT_TRACK_LO +: 8];
        end
    end

    // ----------------------------------------
    // Effective data rate
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_rate_r <= fsrs_pkg::FSRS_RATE_250K;
            rate_src_r <= fsrs_pkg::FSRS_SRC_RATE_SEL;
        end else if (wr_en && hit_rs) begin
            eff_rate_r <= pwdata[fsrs_pkg::FSRS_RS_RATE_HI:fsrs_pkg::FSRS_RS_RATE_LO];
            rate_src_r <= fsrs_pkg::FSRS_SRC_RATE_SEL;
        end else if (wr_en && hit_ctl && pwdata[fsrs_pkg::FSRS_CT_DCR_WRITE]) begin
            eff_rate_r <= pwdata[fsrs_pkg::FSRS_CT_DCR_LO +: 2];
            rate_src_r <= fsrs_pkg::FSRS_SRC_DCR;
        end
    end
    assign rate_code = eff_rate_r;

    // ----------------------------------------
    // Software reset
    // ----------------------------------------
    // Pulse lasts one cycle after the write, then clears by itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= wr_en && hit_rs && pwdata[fsrs_pkg::FSRS_RS_RESET];
        end
    end

    // Output-register reset holds; rate select pulse only adds to it
    assign core_reset = !out_reset_n_r || soft_reset_r;

    // ----------------------------------------
    // Manual power down
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_r <= 1'b0;
        end else if (core_reset) begin
            power_down_r <= 1'b0;
        end else if (access && (hit_data || (hit_rs && !pwrite))) begin
            power_down_r <= 1'b0;
        end else if (wr_en && hit_rs && pwdata[fsrs_pkg::FSRS_RS_PDOWN]) begin
            power_down_r <= 1'b1;
        end
    end
    assign core_clk_en = !power_down_r;

    // ----------------------------------------
    // Separator clock divider
    // ----------------------------------------
    always_comb begin
        case (eff_rate_r)
            fsrs_pkg::FSRS_RATE_500K: div_max = fsrs_pkg::FSRS_DIV_500K;
            fsrs_pkg::FSRS_RATE_300K: div_max = fsrs_pkg::FSRS_DIV_300K;
            fsrs_pkg::FSRS_RATE_250K: div_max = fsrs_pkg::FSRS_DIV_250K;
            fsrs_pkg::FSRS_RATE_1M: div_max = fsrs_pkg::FSRS_DIV_1M;
            default: div_max = fsrs_pkg::FSRS_DIV_250K;
        endcase
    end

    // Compare with >= so a smaller divisor takes effect without a long wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 8'h00;
            sep_tick_r <= 1'b0;
        end else if (power_down_r || core_reset) begin
            div_cnt_r <= 8'h00;
            sep_tick_r <= 1'b0;
        end else if (div_cnt_r >= div_max) begin
            div_cnt_r <= 8'h00;
            sep_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            sep_tick_r <= 1'b0;
        end
    end
    assign sep_clk_en = sep_tick_r;

    // ----------------------------------------
    // Write precompensation
    // ----------------------------------------
    fsrs_precomp u_precomp (
        .pclk(pclk),
        .presetn(presetn),
        .core_reset(core_reset),
        .pre_code(rate_sel_r[fsrs_pkg::FSRS_RS_PRE_HI:fsrs_pkg::FSRS_RS_PRE_LO]),
        .rate_code(eff_rate_r),
        .enable(current_track >= track_start_r),
        .wr_data_in(wr_data_in),
        .wr_data_out(wr_data_out)
    );
endmodule : fsrs_top
`default_nettype wire

// *** design/fsrs_pkg.sv ***
// Package for the floppy status and rate select block.
// Assumes an APB master with 32-bit data; registers take one aligned word, except the data touch at 05h.
package fsrs_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] FSRS_OFS_STATUS_RATE = 8'h04;
    localparam logic [7:0] FSRS_OFS_CONTROL = 8'h10;
    localparam logic [7:0] FSRS_OFS_CORE = 8'h14;
    localparam logic [7:0] FSRS_OFS_RATE_VIEW = 8'h18;
    localparam logic [7:0] FSRS_OFS_DATA_TOUCH = 8'h05;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FSRS_MS_REQ = 7;
    localparam int FSRS_MS_DIR = 6;
    localparam int FSRS_MS_NDMA = 5;
    localparam int FSRS_MS_BUSY = 4;
    localparam int FSRS_MS_SEEK1 = 1;
    localparam int FSRS_MS_SEEK0 = 0;
    localparam int FSRS_RS_RESET = 7;
    localparam int FSRS_RS_PDOWN = 6;
    localparam int FSRS_RS_PRE_HI = 4;
    localparam int FSRS_RS_PRE_LO = 2;
    localparam int FSRS_RS_RATE_HI = 1;
    localparam int FSRS_RS_RATE_LO = 0;
    localparam int FSRS_CT_OUT_RESET_N = 0;
    localparam int FSRS_CT_DCR_WRITE = 1;
    localparam int FSRS_CT_DCR_LO = 8;
    localparam int FSRS_CT_TRACK_LO = 16;

    // ----------------------------------------
    // Reset values and encodings
    // ----------------------------------------
    localparam logic [7:0] FSRS_RATE_SEL_RESET = 8'h02;
    localparam logic [7:0] FSRS_TRACK_RESET = 8'h00;
    localparam logic [1:0] FSRS_RATE_500K = 2'h0;
    localparam logic [1:0] FSRS_RATE_300K = 2'h1;
    localparam logic [1:0] FSRS_RATE_250K = 2'h2;
    localparam logic [1:0] FSRS_RATE_1M = 2'h3;
    localparam logic [2:0] FSRS_PRE_ZERO = 3'h7;
    localparam logic [2:0] FSRS_PRE_41 = 3'h1;
    localparam logic [2:0] FSRS_PRE_83 = 3'h2;
    localparam logic [2:0] FSRS_PRE_125 = 3'h3;
    localparam logic [2:0] FSRS_PRE_166 = 3'h4;
    localparam logic [2:0] FSRS_PRE_208 = 3'h5;
    localparam logic [2:0] FSRS_PRE_250 = 3'h6;

    // ----------------------------------------
    // Separator clock divisors at 25 MHz
    // ----------------------------------------
    localparam logic [7:0] FSRS_DIV_500K = 8'h19;
    localparam logic [7:0] FSRS_DIV_300K = 8'h29;
    localparam logic [7:0] FSRS_DIV_250K = 8'h32;
    localparam logic [7:0] FSRS_DIV_1M = 8'h0c;

    typedef enum logic [1:0] {
        FSRS_SRC_RATE_SEL,
        FSRS_SRC_DCR
    } fsrs_src_type;
endpackage : fsrs_pkg

// *** design/fsrs_precomp.sv ***
// Write precompensation delay line for the write data output.
// Assumes write data pulses and precomp code on pclk.
`timescale 1ns/1ps
`default_nettype none
module fsrs_precomp (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_reset,
    input wire logic [2:0] pre_code,
    input wire logic [1:0] rate_code,
    input wire logic enable,
    input wire logic wr_data_in,
    output logic wr_data_out
);
    // ----------------------------------------
    // Delay in pclk steps
    // ----------------------------------------
    // 40 ns clock: nearest whole steps, coarse by nature
    logic [2:0] steps;
    logic [7:0] shift_r;

    always_comb begin
        case (pre_code)
            fsrs_pkg::FSRS_PRE_ZERO: steps = 3'h0;
            fsrs_pkg::FSRS_PRE_41: steps = 3'h1;
            fsrs_pkg::FSRS_PRE_83: steps = 3'h2;
            fsrs_pkg::FSRS_PRE_125: steps = 3'h3;
            fsrs_pkg::FSRS_PRE_166: steps = 3'h4;
            fsrs_pkg::FSRS_PRE_208: steps = 3'h5;
            fsrs_pkg::FSRS_PRE_250: steps = 3'h6;
            default: begin
                // Default delay depends on the data rate
                steps = (rate_code == fsrs_pkg::FSRS_RATE_1M) ? 3'h1 : 3'h3;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 8'h00;
        end else if (core_reset) begin
            shift_r <= 8'h00;
        end else begin
            shift_r <= {shift_r[6:0], wr_data_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_data_out <= 1'b0;
        end else if (!enable || steps == 3'h0) begin
            wr_data_out <= wr_data_in;
        end else begin
            wr_data_out <= shift_r[steps - 3'h1];
        end
    end
endmodule : fsrs_precomp
`default_nettype wire

// *** test/fsrs_host.sv ***
// Host processor model: APB master tasks for the status/rate block.
// Assumes a slave whose read data stands while pready is high.
`timescale 1ns/1ps
`default_nettype none
module fsrs_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Read data is taken only at the edge that sees pready high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask : rd

    // Read status once before each data byte, outside DMA mode; bit 7 is not waited on
    task automatic data_byte(output logic [31:0] q);
        rd(8'h04, q);
        rd(8'h05, q);
    endtask : data_byte
endmodule : fsrs_host
`default_nettype wire

// *** test/fsrs_top_chk.sv ***
// Checker for the status/rate block, bound to its top module.
// Assumes APB read data loaded in setup and standing in the access cycle.
`timescale 1ns/1ps
`default_nettype none
module fsrs_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic host_request_flag,
    input wire logic transfer_direction,
    input wire logic non_dma_flag,
    input wire logic command_busy,
    input wire logic second_drive_seek_busy,
    input wire logic first_drive_seek_busy,
    input wire logic core_reset,
    input wire logic core_clk_en,
    input wire logic [1:0] rate_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd_st;
    logic wr_rs;
    assign acc = psel && penable;
    assign rd_st = acc && !pwrite && paddr == 8'h04;
    assign wr_rs = acc && pwrite && paddr == 8'h04;

    // ----------------------------------------
    // Status, rate select and unmapped addresses
    // ----------------------------------------
    stat_req_a: assert property (rd_st |-> prdata[7] == $past(host_request_flag))
        else $error("status bit 7 wrong");
    stat_dir_a: assert property (rd_st |-> prdata[6] == $past(transfer_direction))
        else $error("status bit 6 wrong");
    stat_ndma_a: assert property (rd_st |-> prdata[5] == $past(non_dma_flag))
        else $error("status bit 5 wrong");
    stat_busy_a: assert property (rd_st |-> prdata[4] == $past(command_busy))
        else $error("status bit 4 wrong");
    stat_seek_a: assert property (rd_st |-> prdata[3:0] ==
        {2'b00, $past(second_drive_seek_busy), $past(first_drive_seek_busy)}) else $error("seek bits wrong");
    soft_rst_a: assert property (wr_rs && pwdata[7] |=> core_reset)
        else $error("soft reset missing");
    rate_sel_a: assert property (wr_rs |=> rate_code == $past(pwdata[1:0]))
        else $error("rate not taken");
    pdown_set_a: assert property (wr_rs && pwdata[6] && !pwdata[7] && !core_reset |=> !core_clk_en)
        else $error("power down not set");
    wake_st_a: assert property (rd_st |=> core_clk_en)
        else $error("status read did not wake");
    unmap_err_a: assert property (acc && !(paddr inside {8'h04, 8'h05, 8'h10, 8'h14, 8'h18}) |-> pslverr)
        else $error("unmapped access not refused");
endmodule : fsrs_top_chk
`default_nettype wire

bind fsrs_top fsrs_top_chk u_fsrs_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .host_request_flag, .transfer_direction, .non_dma_flag, .command_busy,
    .second_drive_seek_busy, .first_drive_seek_busy, .core_reset, .core_clk_en, .rate_code);

// *** test/tb_fsrs_top.sv ***
// Self-checking bench for the status/rate block.
// Assumes the host model drives APB and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_fsrs_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdi, core_reset, core_clk_en;
    logic sep_clk_en, wdo;
    logic [7:0] paddr, trk;
    logic [31:0] pwdata, prdata, q, q0;
    logic [5:0] st;
    logic [1:0] rate_code;
    int fails = 0;
    int checked = 0;

    fsrs_host u_fsrs_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    fsrs_top u_fsrs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_request_flag(st[5]), .transfer_direction(st[4]),
        .non_dma_flag(st[3]), .command_busy(st[2]), .second_drive_seek_busy(st[1]),
        .first_drive_seek_busy(st[0]), .current_track(trk), .wr_data_in(wdi),
        .wr_data_out(wdo), .core_reset(core_reset), .core_clk_en(core_clk_en),
        .sep_clk_en(sep_clk_en), .rate_code(rate_code));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Toggling write data keeps the precomp path busy
    always @(posedge pclk) wdi <= ~wdi;

    // ----------------------------------------
    // Checking and ending
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        u_fsrs_host.rd(8'h18, q);
        chk(q, 32'h0000_0002, "reset rate");
        chk({30'h0, rate_code}, 32'h0000_0002, "reset rate port");
        chk({31'h0, core_reset}, 32'h0000_0001, "core held");
        $display("reset test done");
    endtask : t_reset

    task automatic t_status();
        for (int i = 0; i < 8; i++) begin
            st <= (i < 6) ? 6'h01 << i : (i == 6 ? 6'h3f : 6'h00);
            u_fsrs_host.rd(8'h04, q);
            chk(q, {24'h0, st[5:2], 2'b00, st[1:0]}, "status");
        end
        u_fsrs_host.rd(8'h0c, q0);
        chk(q0, 32'h0000_0000, "unmapped read");
        $display("status test done");
    endtask : t_status

    task automatic t_rate();
        u_fsrs_host.wr(8'h10, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            u_fsrs_host.wr(8'h04, 32'h0000_0020 | (i << 2) | (i & 3));
            u_fsrs_host.rd(8'h18, q);
            chk(q, 32'(i & 3), "rate");
        end
        u_fsrs_host.wr(8'h10, 32'h0000_0103);
        @(negedge pclk);
        chk({30'h0, rate_code}, 32'h0000_0001, "control rate");
        u_fsrs_host.rd(8'h18, q);
        chk(q, 32'h0000_0005, "control source");
        u_fsrs_host.wr(8'h04, 32'h0000_0003);
        @(negedge pclk);
        chk({30'h0, rate_code}, 32'h0000_0003, "latest rate");
        $display("rate test done");
    endtask : t_rate

    task automatic t_soft();
        u_fsrs_host.wr(8'h04, 32'h0000_0081);
        @(negedge pclk);
        chk({31'h0, core_reset}, 32'h0000_0001, "soft pulse");
        @(negedge pclk);
        chk({31'h0, core_reset}, 32'h0000_0000, "self clear");
        u_fsrs_host.wr(8'h10, 32'h0000_0000);
        u_fsrs_host.wr(8'h04, 32'h0000_0081);
        repeat (2) @(negedge pclk);
        chk({31'h0, core_reset}, 32'h0000_0001, "held reset wins");
        u_fsrs_host.rd(8'h18, q);
        chk(q, 32'h0000_0001, "rate kept");
        u_fsrs_host.wr(8'h10, 32'h0000_0001);
        $display("soft reset test done");
    endtask : t_soft

    task automatic t_pdown();
        u_fsrs_host.wr(8'h04, 32'h0000_0042);
        @(negedge pclk);
        chk({31'h0, core_clk_en}, 32'h0000_0000, "clocks off");
        u_fsrs_host.rd(8'h05, q);
        @(negedge pclk);
        chk({31'h0, core_clk_en}, 32'h0000_0001, "data wake");
        u_fsrs_host.wr(8'h04, 32'h0000_0042);
        u_fsrs_host.rd(8'h04, q);
        @(negedge pclk);
        chk({31'h0, core_clk_en}, 32'h0000_0001, "status wake");
        u_fsrs_host.data_byte(q);
        chk(q, 32'h0000_0000, "data touch read");
        u_fsrs_host.wr(8'h04, 32'h0000_0042);
        u_fsrs_host.wr(8'h04, 32'h0000_0082);
        repeat (2) @(negedge pclk);
        chk({31'h0, core_clk_en}, 32'h0000_0001, "reset wake");
        $display("power down test done");
    endtask : t_pdown

    task automatic t_sep();
        int n;
        u_fsrs_host.wr(8'h04, 32'h0000_0003);
        n = 0;
        @(negedge pclk);
        while (sep_clk_en !== 1'b1) @(negedge pclk);
        do begin
            @(negedge pclk);
            n++;
        end while (sep_clk_en !== 1'b1);
        chk(n, int'(fsrs_pkg::FSRS_DIV_1M) + 1, "separator period");
        $display("separator test done");
    endtask : t_sep

    // Toggling data: one step of delay flips its phase against zero delay
    task automatic t_precomp();
        u_fsrs_host.wr(8'h10, 32'h0005_0001);
        u_fsrs_host.wr(8'h04, 32'h0000_0006);
        repeat (2) @(negedge pclk);
        chk({31'h0, wdo}, {31'h0, ~wdi}, "precomp below start");
        @(posedge pclk);
        trk <= 8'h05;
        repeat (3) @(negedge pclk);
        chk({31'h0, wdo}, {31'h0, wdi}, "precomp one step");
        u_fsrs_host.wr(8'h04, 32'h0000_001e);
        repeat (2) @(negedge pclk);
        chk({31'h0, wdo}, {31'h0, ~wdi}, "precomp zero");
        $display("precomp test done");
    endtask : t_precomp

    initial begin
        presetn = 1'b0;
        st = 6'h00;
        wdi = 1'b0;
        trk = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_status();
        t_rate();
        t_soft();
        t_pdown();
        t_sep();
        t_precomp();
        wrap_up();
    end

    // Whole run is a few hundred cycles
    initial begin
        repeat (4000) @(posedge pclk);
        fails++;
        wrap_up();
    end
endmodule : tb_fsrs_top
`default_nettype wire
